// ### logic/sfp_pkg.sv
// sfp_pkg: constants for the synchronous fifo primitive
// assumes: single clock domain, no software-visible registers
package sfp_pkg;
    localparam int SFP_DATA_WIDTH = 8;
    localparam int SFP_DEPTH = 16;
    localparam int SFP_OBUF_DEPTH = 2;
    localparam logic [0:0] SFP_FLAG_RESET = 1'h0;
    localparam logic [0:0] SFP_EMPTY_RESET = 1'h1;
endpackage

// ### logic/sfp_fifo.sv
// sfp_fifo: single-clock fifo with full, empty and fill count, plus a
// two-entry output buffer so a stalled receiver loses no word
// assumes: requests synchronous to ref_clk, user applies a clear
//
// Behaviour
// - no clock edge, nothing changes except on an asynchronous sys_rst
// - write alone stores word as newest
// - read alone pops oldest into the output buffer if it has room
// - both requests: write and read together
// - full ignores write, read still served
// - empty ignores read, write still served
// - fill count gives words held in storage, not those in the output buffer
// - full and empty flags reflect occupancy
`timescale 1ns/100ps
`default_nettype none
module sfp_fifo
    import sfp_pkg::*;
#(
    parameter int DATA_WIDTH = SFP_DATA_WIDTH,
    parameter int DEPTH = SFP_DEPTH,
    parameter int AW = $clog2(DEPTH),
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic sync_clear,
    input wire logic clk_en,
    input wire logic [DATA_WIDTH-1:0] write_data,
    input wire logic write_request,
    input wire logic read_request,
    output logic [DATA_WIDTH-1:0] read_data,
    output logic read_valid,
    input wire logic read_ready,
    output logic full,
    output logic empty,
    output logic [CW-1:0] fill_count
);
    ////////////////////////////////////////////////////////////////////////
    // storage and pointers
    logic [DATA_WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    // output buffer: two entries, slot 0 is the head
    logic [DATA_WIDTH-1:0] obuf_q [SFP_OBUF_DEPTH];
    logic [1:0] obuf_cnt_q;
    logic [1:0] obuf_cnt_d;

    wire logic obuf_room = (obuf_cnt_q < 2'(SFP_OBUF_DEPTH)) || (read_valid && read_ready);
    wire logic full_w = (count_q == CW'(DEPTH));
    wire logic empty_w = (count_q == '0);
    wire logic wr_go = write_request && !full_w;
    wire logic rd_go = read_request && !empty_w && obuf_room;
    wire logic pop_out = read_valid && read_ready;
    wire logic [AW-1:0] wr_ptr_nx = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    wire logic [AW-1:0] rd_ptr_nx = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    wire logic step = clk_en && !sync_clear;

    assign count_d = count_q + CW'(wr_go) - CW'(rd_go);
    assign obuf_cnt_d = obuf_cnt_q + 2'(rd_go) - 2'(pop_out);
    assign full = full_w;
    assign empty = empty_w;
    assign fill_count = count_q;
    assign read_valid = (obuf_cnt_q != 2'h0);
    assign read_data = obuf_q[0];

    ////////////////////////////////////////////////////////////////////////
    // memory write
    always_ff @(posedge ref_clk) begin
        if (step && wr_go) begin
            mem_q[wr_ptr_q] <= write_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers and count; clear with clk_en high forces empty
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            obuf_cnt_q <= '0;
        end else if (clk_en && sync_clear) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            obuf_cnt_q <= '0;
        end else if (step) begin
            if (wr_go) begin
                wr_ptr_q <= wr_ptr_nx;
            end
            if (rd_go) begin
                rd_ptr_q <= rd_ptr_nx;
            end
            count_q <= count_d;
            obuf_cnt_q <= obuf_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer data: one slot per entry, slot 0 is the head; on a pop every
    // slot but the tail takes the word behind it, and a fetched word lands in the next free slot
    // after the pop, so the receiver can stall without losing a word
    wire logic [1:0] ins_slot = obuf_cnt_q - 2'(pop_out);
    wire logic [DATA_WIDTH-1:0] fetch_word = mem_q[rd_ptr_q];

    genvar g;
    for (g = 0; g < SFP_OBUF_DEPTH; g++) begin : g_slot
        wire logic load_here = rd_go && (ins_slot == 2'(g));
        wire logic [DATA_WIDTH-1:0] behind;
        if (g + 1 < SFP_OBUF_DEPTH) begin : g_inner
            assign behind = obuf_q[g + 1];
        end else begin : g_tail
            // the tail has nothing behind it and keeps its word
            assign behind = obuf_q[g];
        end
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                obuf_q[g] <= '0;
            end else if (step) begin
                if (load_here) begin
                    obuf_q[g] <= fetch_word;
                end else if (pop_out) begin
                    obuf_q[g] <= behind;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // refusals leave the pointer that would have moved untouched
    property p_full_no_write;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && !sync_clear && full && write_request)
            |=> $stable(wr_ptr_q) && (full || $past(read_request));
    endproperty
    a_full_no_write: assert property (p_full_no_write) else $error("write taken while full");

    property p_empty_no_read;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && !sync_clear && empty && read_request)
            |=> $stable(rd_ptr_q) && (fill_count == CW'($past(write_request)))
                && (obuf_cnt_q <= $past(obuf_cnt_q));
    endproperty
    a_empty_no_read: assert property (p_empty_no_read) else $error("read taken while empty");

    property p_write_count;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && !sync_clear && wr_go && !rd_go) |=> fill_count == $past(fill_count) + 1'b1;
    endproperty
    a_write_count: assert property (p_write_count) else $error("write did not raise count");

    property p_read_count;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && !sync_clear && rd_go && !wr_go) |=> fill_count == $past(fill_count) - 1'b1;
    endproperty
    a_read_count: assert property (p_read_count) else $error("read did not lower count");

    property p_both_count;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && !sync_clear && rd_go && wr_go) |=> $stable(fill_count) && read_valid;
    endproperty
    a_both_count: assert property (p_both_count) else $error("simultaneous op wrong");

    property p_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && !sync_clear && !write_request && !read_request && !pop_out)
            |=> $stable(fill_count) && $stable(read_data) && $stable(read_valid);
    endproperty
    a_idle: assert property (p_idle) else $error("idle cycle changed state");

    property p_frozen;
        @(posedge ref_clk) disable iff (sys_rst)
        !clk_en |=> $stable(fill_count) && $stable(read_data) && $stable(read_valid);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved without enable");

    property p_flags;
        @(posedge ref_clk) disable iff (sys_rst)
        (full == (fill_count == CW'(DEPTH))) && (empty == (fill_count == '0))
            && fill_count <= CW'(DEPTH)
            && (full || empty || (wr_ptr_q != rd_ptr_q));
    endproperty
    a_flags: assert property (p_flags) else $error("flags disagree with count");

    property p_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (clk_en && sync_clear) |=> empty && !read_valid;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty fifo");

    // a taken read moves one word into the output buffer
    sequence s_read_taken;
        clk_en && !sync_clear && rd_go && !pop_out;
    endsequence
    sequence s_word_waiting;
        read_valid && (obuf_cnt_q == $past(obuf_cnt_q) + 2'h1);
    endsequence
    property p_read_lands;
        @(posedge ref_clk) disable iff (sys_rst)
        s_read_taken |=> s_word_waiting;
    endproperty
    a_read_lands: assert property (p_read_lands) else $error("taken read did not land");

    // into an empty output buffer the oldest stored word becomes the head
    sequence s_fetch_to_idle_head;
        clk_en && !sync_clear && rd_go && !read_valid;
    endsequence
    property p_head_word;
        @(posedge ref_clk) disable iff (sys_rst)
        s_fetch_to_idle_head |=> read_data == $past(fetch_word);
    endproperty
    a_head_word: assert property (p_head_word) else $error("head word not the oldest");

    // flags rise only by a taken request or a clear
    property p_full_rise;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(full) |-> $past(step) && $past(wr_go) && !$past(rd_go);
    endproperty
    a_full_rise: assert property (p_full_rise) else $error("full rose without a write");

    property p_empty_rise;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(empty) |-> ($past(step) && $past(rd_go)) || $past(clk_en && sync_clear);
    endproperty
    a_empty_rise: assert property (p_empty_rise) else $error("empty rose with no read");
endmodule
`default_nettype wire

// ### verif/sfp_sink.sv
// sfp_sink: receiver model that takes words off the read side
// assumes: the bench raises stall to hold words back
`timescale 1ns/100ps
`default_nettype none
module sfp_sink
    import sfp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic read_valid,
    input wire logic [SFP_DATA_WIDTH-1:0] read_data,
    output logic read_ready
);
    logic [SFP_DATA_WIDTH-1:0] got[$];
    assign read_ready = !stall;
    always @(posedge ref_clk) begin
        if (read_valid === 1'h1 && read_ready) begin
            got.push_back(read_data);
        end
    end
endmodule
`default_nettype wire

// ### verif/sfp_fifo_bench.sv
// sfp_fifo_bench: self-checking bench for sfp_fifo
// assumes: default depth 16, inputs driven 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module sfp_fifo_bench
    import sfp_pkg::*;
;
    typedef struct {logic e, w, r; logic [7:0] d; logic [4:0] f;} sfp_row_t;
    logic ref_clk = 1'h0, sys_rst = 1'h1, sync_clear = 1'h0, clk_en = 1'h1;
    logic write_request = 1'h0, read_request = 1'h0, stall = 1'h0, read_valid, read_ready;
    logic full, empty;
    logic [7:0] write_data = 8'h00, read_data, exp_q[$];
    logic [4:0] fill_count;
    int failures = 0, n_compared = 0;
    sfp_row_t rows[5] = '{'{1'h1, 1'h0, 1'h1, 8'h00, 5'h00}, '{1'h1, 1'h1, 1'h0, 8'hA0, 5'h01},
        '{1'h1, 1'h0, 1'h0, 8'h00, 5'h01}, '{1'h0, 1'h1, 1'h1, 8'h55, 5'h01},
        '{1'h1, 1'h1, 1'h1, 8'hB1, 5'h01}};
    sfp_fifo u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sync_clear(sync_clear),
        .clk_en(clk_en), .write_data(write_data), .write_request(write_request),
        .read_request(read_request), .read_data(read_data), .read_valid(read_valid),
        .read_ready(read_ready), .full(full), .empty(empty), .fill_count(fill_count));
    sfp_sink u_sink (.ref_clk(ref_clk), .stall(stall), .read_valid(read_valid),
        .read_data(read_data), .read_ready(read_ready));
    always #2 ref_clk = !ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_state(input logic [4:0] f);
        chk("fill_count", 8'(f), 8'(fill_count));
        chk("empty", 8'(f == 5'h00), 8'(empty));
        chk("full", 8'(f == 5'h10), 8'(full));
    endtask
    task automatic step(input logic e, input logic w, input logic r, input logic [7:0] d);
        clk_en = e;
        write_request = w;
        read_request = r;
        write_data = d;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("failures %0d n_compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        check_state(5'h00);
        sys_rst = 1'h0;
        foreach (rows[i]) begin
            step(rows[i].e, rows[i].w, rows[i].r, rows[i].d);
            check_state(rows[i].f);
        end
        chk("read_valid", 8'h01, 8'(read_valid));
        chk("read_data", 8'hA0, read_data);
        exp_q = '{8'hA0, 8'hB1};
        stall = 1'h1;
        for (int i = 0; i < 15; i++) begin
            step(1'h1, 1'h1, 1'h0, 8'(8'h10 + i));
            exp_q.push_back(8'(8'h10 + i));
        end
        check_state(5'h10);
        step(1'h1, 1'h1, 1'h0, 8'hFF);
        check_state(5'h10);
        step(1'h1, 1'h1, 1'h1, 8'hEE);
        check_state(5'h0F);
        stall = 1'h0;
        for (int n = 0; n < 60 && !(empty === 1'h1 && read_valid === 1'h0); n++) begin
            step(1'h1, 1'h0, 1'h1, 8'h00);
        end
        step(1'h1, 1'h0, 1'h0, 8'h00);
        chk("words", 8'h11, 8'(u_sink.got.size()));
        foreach (exp_q[i]) chk("word", exp_q[i], u_sink.got[i]);
        stall = 1'h1;
        step(1'h1, 1'h1, 1'h0, 8'h01);
        step(1'h1, 1'h1, 1'h1, 8'h02);
        check_state(5'h01);
        chk("read_valid", 8'h01, 8'(read_valid));
        chk("read_data", 8'h01, read_data);
        sync_clear = 1'h1;
        step(1'h1, 1'h0, 1'h0, 8'h00);
        sync_clear = 1'h0;
        check_state(5'h00);
        chk("read_valid", 8'h00, 8'(read_valid));
        step(1'h1, 1'h1, 1'h0, 8'h03);
        sys_rst = 1'h1;
        step(1'h1, 1'h0, 1'h0, 8'h00);
        check_state(5'h00);
        chk("read_valid", 8'h00, 8'(read_valid));
        sys_rst = 1'h0;
        step(1'h1, 1'h1, 1'h0, 8'h04);
        check_state(5'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
